/* src/hpc_top.sv */
// slot hot-plug controller front end: straps, mode, slot links, cfg read
// assumes synchronous inputs on clk_i and a one-cycle read/write strobe
// What this block does
// - never serve more than six hot-plug slots.
// - serial mode serves three to six slots, parallel one or two.
// - serial input link polls slot inputs continuously, unasked.
// - serial output link shifts only when an output change is pending.
// - serial link clock is clk_i/2 (5 MHz at the 10 MHz clk_i), independent of bus speed.
// - parallel mode keeps internal serial stream, external link stays quiet.
// - capture straps on power-good rising edge and hold them.
// - strap msb zero disables controller and hides its registers.
// - slot count reads in bits 4:0 of register at offset 0ch.
// - slot count register is read-only; writes never change mode.
// - enabled straps select parallel 1/2, serial 3-6, no-glue, reserved.
// - disabled straps report lower three bits plus one.
// - six control outputs per slot.
// - power enable drives slot regulator; its fault returns as input.
// - active-low clock enable connects slot clock through switches.
// - active-low bus enable connects slot signals through switches.
// - active-low slot reset drives the slot reset pin.
// - active-low attention and power indicator outputs per slot.
// - one controller per bridge, serving only its secondary bus.
// - input poll frame is 48 bits, eight per slot; absent slots ones.
// - output frame is 36 bits, six per slot, highest slot first.
`timescale 1ns/1ns
`default_nettype none
`include "hpc_consts.svh"

module hpc_top
  import hpc_pkg::*;
#(
  parameter int SCLK_HALF = ((`HPC_CLK_HZ / (2 * `HPC_SCLK_HZ)) < 1) ? 1 :
                            (`HPC_CLK_HZ / (2 * `HPC_SCLK_HZ))
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic power_good_input_i,
  input wire logic [3:0] hotplug_strap_i,
  input wire logic reg_rd_i,
  input wire logic reg_wr_i,
  input wire logic [7:0] reg_addr_i,
  output logic [31:0] reg_rdata_o,
  output logic reg_ack_o,
  input wire logic ctrl_req_i,
  input wire logic [35:0] ctrl_data_i,
  output logic ctrl_busy_o,
  output logic [47:0] slot_status_o,
  output logic status_valid_o,
  output logic ser_clk_o,
  output logic ser_in_load_n_o,
  input wire logic ser_sid_i,
  output logic ser_sod_o,
  output logic ser_out_latch_o,
  input wire logic [7:0] par_in_slot1_i,
  input wire logic [7:0] par_in_slot2_i,
  output logic [1:0] par_power_on_o,
  output logic [1:0] par_clock_conn_n_o,
  output logic [1:0] par_bus_conn_n_o,
  output logic [1:0] par_slot_rst_n_o,
  output logic [1:0] power_indicator_led_n_o,
  output logic [1:0] attention_led_n_o,
  output logic hp_enabled_o,
  output logic serial_mode_o,
  output logic [4:0] slot_count_o
);

  default clocking cb_chk @(posedge clk_i);
  endclocking

  default disable iff (!nrst_i);

  // strap decode: slot count for any strap setting
  function automatic logic [4:0] decode_cnt(input logic [3:0] s);
    logic [4:0] c;
    c = 5'h00;
    if (!s[`HPC_STRAP_EN]) begin
      c = {2'h0, s[2:0]} + 5'h01;
    end else begin
      unique case (s)
        `HPC_STRAP_P1: c = `HPC_CNT_1;
        `HPC_STRAP_P2: c = `HPC_CNT_2;
        `HPC_STRAP_S3: c = `HPC_CNT_3;
        `HPC_STRAP_S4: c = `HPC_CNT_4;
        `HPC_STRAP_S5: c = `HPC_CNT_5;
        `HPC_STRAP_S6: c = `HPC_CNT_6;
        `HPC_STRAP_NOGLUE: c = `HPC_CNT_1;
        default: c = 5'h00;
      endcase
    end
    return c;
  endfunction : decode_cnt

  function automatic logic strap_serial(input logic [3:0] s);
    return (s == `HPC_STRAP_S3) || (s == `HPC_STRAP_S4) ||
           (s == `HPC_STRAP_S5) || (s == `HPC_STRAP_S6);
  endfunction : strap_serial

  // parallel pins seen as the serial input stream, bit k of the frame
  function automatic logic par_bit(input logic [5:0] k,
                                   input logic [4:0] cnt,
                                   input logic [7:0] in1,
                                   input logic [7:0] in2);
    logic b;
    b = 1'b1;
    if (k[5:3] == 3'h0) begin
      b = in1[3'h7 - k[2:0]];
    end else if (k[5:3] == 3'h1 && cnt == `HPC_CNT_2) begin
      b = in2[3'h7 - k[2:0]];
    end
    return b;
  endfunction : par_bit

  // slots above the count read as idle ones
  function automatic logic [47:0] mask_status(input logic [47:0] d,
                                              input logic [4:0] cnt);
    logic [47:0] m;
    m = d;
    for (int j = 0; j < `HPC_MAX_SLOTS; j++) begin
      if (5'(j) >= cnt) begin
        m[47 - 8 * j -: 8] = `HPC_IN_IDLE;
      end
    end
    return m;
  endfunction : mask_status

  logic pg_q_ff;
  logic [3:0] strap_ff;
  logic captured_ff;
  logic op_ff;
  logic serial_ff;
  logic [4:0] cnt_ff;
  logic visible_ff;
  hpc_state_e state_ff;
  hpc_state_e nxt_state;
  logic [3:0] div_ff;
  logic phase_ff;
  logic tick;
  logic shifting;
  logic pend_ff;
  logic nxt_pend;
  logic [35:0] ctrl_ff;
  logic [11:0] par_ff;
  logic in_busy;
  logic in_done;
  logic [5:0] in_idx;
  logic [47:0] in_data;
  logic out_busy;
  logic out_done;
  logic out_sdo;
  logic [35:0] out_data;
  logic in_sdi;
  logic pg_rise;
  logic link_run;

  assign pg_rise = power_good_input_i && !pg_q_ff;

  // strap capture on power-good rise, held afterwards
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pg_q_ff <= 1'b0;
      strap_ff <= 4'h0;
      captured_ff <= 1'b0;
    end else begin
      pg_q_ff <= power_good_input_i;
      if (pg_rise) begin
        strap_ff <= hotplug_strap_i;
        captured_ff <= 1'b1;
      end
    end
  end

  // mode derived from held straps; one instance per secondary bus
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      op_ff <= 1'b0;
      serial_ff <= 1'b0;
      cnt_ff <= 5'h00;
      visible_ff <= 1'b0;
    end else begin
      visible_ff <= captured_ff && strap_ff[`HPC_STRAP_EN];
      op_ff <= captured_ff && strap_ff[`HPC_STRAP_EN] &&
               (strap_ff != `HPC_STRAP_RSVD);
      serial_ff <= captured_ff && strap_serial(strap_ff);
      cnt_ff <= captured_ff ? decode_cnt(strap_ff) : 5'h00;
    end
  end

  assign hp_enabled_o = op_ff;
  assign serial_mode_o = serial_ff;
  assign slot_count_o = cnt_ff;

  // register read port; no write path reaches the count
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      reg_ack_o <= 1'b0;
      reg_rdata_o <= 32'h0;
    end else begin
      reg_ack_o <= visible_ff && (reg_rd_i || reg_wr_i);
      if (visible_ff && reg_rd_i && reg_addr_i == `HPC_CFG_OFS) begin
        reg_rdata_o <= {27'h0, cnt_ff};
      end else begin
        reg_rdata_o <= 32'h0;
      end
    end
  end

  // link clock divider, runs only while a frame shifts
  assign shifting = (state_ff == HPC_POLL) || (state_ff == HPC_PUSH);
  // no link clock once the last bit of a frame has gone
  assign link_run = (in_busy && state_ff == HPC_POLL) ||
                    (out_busy && state_ff == HPC_PUSH);

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      div_ff <= 4'h0;
      phase_ff <= 1'b0;
    end else if (!shifting) begin
      div_ff <= 4'h0;
      phase_ff <= 1'b0;
    end else if (div_ff == 4'(SCLK_HALF - 1)) begin
      div_ff <= 4'h0;
      phase_ff <= !phase_ff;
    end else begin
      div_ff <= div_ff + 4'h1;
    end
  end

  assign tick = shifting && phase_ff && (div_ff == 4'(SCLK_HALF - 1));

  // output change requests; a new request wins over the clear
  always_comb begin
    nxt_pend = pend_ff;
    if (state_ff == HPC_POLL && in_done && pend_ff) begin
      nxt_pend = 1'b0;
    end
    if (ctrl_req_i && op_ff) begin
      nxt_pend = 1'b1;
    end
    if (!op_ff) begin
      nxt_pend = 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pend_ff <= 1'b0;
      ctrl_ff <= {`HPC_MAX_SLOTS{`HPC_SLOT_IDLE}};
    end else begin
      pend_ff <= nxt_pend;
      if (ctrl_req_i && op_ff) begin
        ctrl_ff <= ctrl_data_i;
      end
    end
  end

  // sequencer: poll forever, push only on demand
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      HPC_OFF: nxt_state = op_ff ? HPC_LOAD : HPC_OFF;
      HPC_LOAD: nxt_state = HPC_POLL;
      HPC_POLL: begin
        if (in_done) begin
          nxt_state = pend_ff ? HPC_PUSH : HPC_LOAD;
        end
      end
      HPC_PUSH: nxt_state = out_done ? HPC_LATCH : HPC_PUSH;
      HPC_LATCH: nxt_state = HPC_LOAD;
      default: nxt_state = HPC_OFF;
    endcase
    if (!op_ff) begin
      nxt_state = HPC_OFF;
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_ff <= HPC_OFF;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // parallel mode feeds the internal stream from the slot pins
  assign in_sdi = serial_ff ? ser_sid_i :
                  par_bit(in_idx, cnt_ff, par_in_slot1_i, par_in_slot2_i);

  hpc_shift #(
    .W(`HPC_IN_BITS),
    .CW(6)
  ) u_poll (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .start_i(state_ff == HPC_LOAD),
    .tick_i(tick && state_ff == HPC_POLL),
    .load_i({`HPC_IN_BITS{1'b1}}),
    .sdi_i(in_sdi),
    .busy_o(in_busy),
    .done_o(in_done),
    .sdo_o(),
    .idx_o(in_idx),
    .data_o(in_data)
  );

  // output frame rotates back onto itself for the parallel pins
  hpc_shift #(
    .W(`HPC_OUT_BITS),
    .CW(6)
  ) u_push (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .start_i(state_ff == HPC_POLL && in_done && pend_ff),
    .tick_i(tick && state_ff == HPC_PUSH),
    .load_i(ctrl_ff),
    .sdi_i(out_sdo),
    .busy_o(out_busy),
    .done_o(out_done),
    .sdo_o(out_sdo),
    .idx_o(),
    .data_o(out_data)
  );

  // poll results, absent slots forced idle
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      slot_status_o <= {`HPC_IN_BITS{1'b1}};
      status_valid_o <= 1'b0;
    end else begin
      status_valid_o <= in_done && op_ff;
      if (!op_ff) begin
        slot_status_o <= {`HPC_IN_BITS{1'b1}};
      end else if (in_done) begin
        slot_status_o <= mask_status(in_data, cnt_ff);
      end
    end
  end

  // external serial pins, quiet outside serial mode
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ser_clk_o <= 1'b0;
      ser_in_load_n_o <= 1'b1;
      ser_sod_o <= 1'b0;
      ser_out_latch_o <= 1'b0;
      ctrl_busy_o <= 1'b0;
    end else begin
      ser_clk_o <= serial_ff && link_run && phase_ff;
      ser_in_load_n_o <= !(serial_ff && state_ff == HPC_LOAD);
      ser_sod_o <= serial_ff && out_busy && out_sdo;
      ser_out_latch_o <= serial_ff && state_ff == HPC_LATCH;
      ctrl_busy_o <= nxt_pend || (nxt_state == HPC_PUSH) ||
                     (nxt_state == HPC_LATCH);
    end
  end

  // parallel slot control pins, slot1 in [5:0], slot2 in [11:6]
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      par_ff <= {2{`HPC_SLOT_IDLE}};
    end else if (!op_ff || serial_ff) begin
      par_ff <= {2{`HPC_SLOT_IDLE}};
    end else if (state_ff == HPC_LATCH) begin
      par_ff[5:0] <= out_data[5:0];
      par_ff[11:6] <= (cnt_ff == `HPC_CNT_2) ? out_data[11:6] :
                      `HPC_SLOT_IDLE;
    end
  end

  assign par_power_on_o = {par_ff[6 + `HPC_B_PWR], par_ff[`HPC_B_PWR]};
  assign par_clock_conn_n_o = {par_ff[6 + `HPC_B_CLK], par_ff[`HPC_B_CLK]};
  assign par_bus_conn_n_o = {par_ff[6 + `HPC_B_BUS], par_ff[`HPC_B_BUS]};
  assign par_slot_rst_n_o = {par_ff[6 + `HPC_B_RST], par_ff[`HPC_B_RST]};
  assign power_indicator_led_n_o = {par_ff[6 + `HPC_B_POWER_INDICATOR_BIT],
                                    par_ff[`HPC_B_POWER_INDICATOR_BIT]};
  assign attention_led_n_o = {par_ff[6 + `HPC_B_ATTENTION_INDICATOR_BIT],
                              par_ff[`HPC_B_ATTENTION_INDICATOR_BIT]};

  // checks
  sequence s_poll_end;
    (state_ff == HPC_POLL) && in_done;
  endsequence

  sequence s_push_tail;
    out_done ##1 (state_ff == HPC_LATCH) ##1 (state_ff == HPC_LOAD);
  endsequence

  chk_slot_max: assert property (
    strap_ff[`HPC_STRAP_EN] |-> cnt_ff <= `HPC_MAX_SLOTS)
    else $error("slot count above six");

  chk_mode_range: assert property (
    op_ff |-> (serial_ff ? (cnt_ff >= `HPC_CNT_3 && cnt_ff <= `HPC_CNT_6)
                         : (cnt_ff >= `HPC_CNT_1 && cnt_ff <= `HPC_CNT_2)))
    else $error("slot count outside mode range");

  chk_poll_again: assert property (
    s_poll_end and (op_ff && !pend_ff) |=> state_ff == HPC_LOAD ##1
      state_ff == HPC_POLL)
    else $error("poll did not restart");

  chk_push_demand: assert property (
    $rose(out_busy) |-> $past(pend_ff) && $past(state_ff) == HPC_POLL)
    else $error("output frame without request");

  chk_push_close: assert property (
    (state_ff == HPC_PUSH) && out_done && op_ff |-> s_push_tail)
    else $error("output frame did not latch");

  chk_sclk_frame: assert property (
    ser_clk_o |-> $past(link_run))
    else $error("link clock outside a frame");

  chk_sclk_half: assert property (
    $rose(ser_clk_o) && SCLK_HALF == 1 |=> !ser_clk_o)
    else $error("link clock high too long");

  chk_par_quiet: assert property (
    !serial_ff |=> !ser_clk_o && ser_in_load_n_o && !ser_sod_o &&
      !ser_out_latch_o)
    else $error("serial activity outside serial mode");

  chk_strap_hold: assert property (
    !pg_rise |=> $stable(strap_ff))
    else $error("straps changed without power-good rise");

  chk_hidden_regs: assert property (
    !visible_ff |=> !reg_ack_o && reg_rdata_o == 32'h0)
    else $error("hidden registers answered");

  chk_cfg_read: assert property (
    visible_ff && reg_rd_i && reg_addr_i == `HPC_CFG_OFS |=>
      reg_ack_o && reg_rdata_o == {27'h0, $past(cnt_ff)})
    else $error("slot count read wrong");

  chk_write_none: assert property (
    reg_wr_i && !pg_rise |=> ##1 $stable(cnt_ff) && $stable(serial_ff))
    else $error("write changed mode");

  chk_off_idle: assert property (
    !op_ff [*2] |-> state_ff == HPC_OFF &&
      par_ff == {2{`HPC_SLOT_IDLE}})
    else $error("disabled controller not idle");

  chk_slot2_idle: assert property (
    cnt_ff != `HPC_CNT_2 |=> par_ff[11:6] == `HPC_SLOT_IDLE)
    else $error("unused second slot driven");

endmodule : hpc_top

`default_nettype wire

/* src/hpc_consts.svh */
// constants for the slot hot-plug controller front end
// assumes inclusion by bare name from every design file that needs it
`ifndef HPC_CONSTS_SVH
`define HPC_CONSTS_SVH

`define HPC_CFG_OFS 8'h0c
`define HPC_CNT_W 5
`define HPC_MAX_SLOTS 5'h06
`define HPC_IN_BITS 48
`define HPC_OUT_BITS 36
`define HPC_IN_PER_SLOT 8
`define HPC_OUT_PER_SLOT 6
`define HPC_STRAP_EN 3
`define HPC_STRAP_RSVD 4'h8
`define HPC_STRAP_P1 4'h9
`define HPC_STRAP_P2 4'ha
`define HPC_STRAP_S3 4'hb
`define HPC_STRAP_S4 4'hc
`define HPC_STRAP_S5 4'hd
`define HPC_STRAP_S6 4'he
`define HPC_STRAP_NOGLUE 4'hf
`define HPC_CNT_1 5'h01
`define HPC_CNT_2 5'h02
`define HPC_CNT_3 5'h03
`define HPC_CNT_4 5'h04
`define HPC_CNT_5 5'h05
`define HPC_CNT_6 5'h06
`define HPC_SLOT_IDLE 6'h1f
`define HPC_IN_IDLE 8'hff
`define HPC_B_PWR 5
`define HPC_B_CLK 4
`define HPC_B_BUS 3
`define HPC_B_RST 2
`define HPC_B_POWER_INDICATOR_BIT 1
`define HPC_B_ATTENTION_INDICATOR_BIT 0
`define HPC_CLK_HZ 10000000
`define HPC_SCLK_HZ 8250000

`endif

/* src/hpc_pkg.sv */
// types shared by the hot-plug controller design files
// assumes nothing beyond a SystemVerilog compiler
package hpc_pkg;

  // sequencer states, gray along off-load-poll-push-latch
  typedef enum logic [2:0] {
    HPC_OFF = 3'h0,
    HPC_LOAD = 3'h1,
    HPC_POLL = 3'h3,
    HPC_PUSH = 3'h2,
    HPC_LATCH = 3'h6
  } hpc_state_e;

endpackage : hpc_pkg

/* src/hpc_shift.sv */
// serial shift engine, msb first out, new bits enter at the lsb
// assumes start and tick never arrive together and tick is one cycle
`timescale 1ns/1ns
`default_nettype none

module hpc_shift #(
  parameter int W = 48,
  parameter int CW = 6
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic start_i,
  input wire logic tick_i,
  input wire logic [W-1:0] load_i,
  input wire logic sdi_i,
  output logic busy_o,
  output logic done_o,
  output logic sdo_o,
  output logic [CW-1:0] idx_o,
  output logic [W-1:0] data_o
);
  localparam logic [CW-1:0] LAST = CW'(W - 1);

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      data_o <= '0;
      busy_o <= 1'b0;
      idx_o <= '0;
    end else if (start_i) begin
      data_o <= load_i;
      busy_o <= 1'b1;
      idx_o <= '0;
    end else if (busy_o && tick_i) begin
      data_o <= {data_o[W-2:0], sdi_i};
      idx_o <= idx_o + 1'b1;
      if (idx_o == LAST) begin
        busy_o <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      done_o <= 1'b0;
    end else begin
      done_o <= busy_o && tick_i && (idx_o == LAST);
    end
  end

  assign sdo_o = data_o[W-1];

endmodule : hpc_shift

`default_nettype wire

/* tb/hpc_glue.sv */
// slot glue model: serializes slot inputs, deserializes slot outputs
// assumes the link clock and strobes are registered on clk_i
`timescale 1ns/1ns
`default_nettype none

module hpc_glue (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic sclk_i,
  input wire logic load_n_i,
  input wire logic sod_i,
  input wire logic latch_i,
  input wire logic [47:0] frame_i,
  output logic sid_o,
  output logic [35:0] out_o
);
  logic [47:0] sh;
  logic [35:0] rx;
  logic sclk_q;

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sclk_q <= 1'b0;
    end else begin
      sclk_q <= sclk_i;
    end
  end

  // msb first, absent slots carry whatever bits the frame holds
  // past the frame the line repeats the frame inverted instead of holding
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sh <= '1;
    end else if (!load_n_i) begin
      sh <= frame_i;
    end else if (sclk_i && !sclk_q) begin
      // next bit follows each rising link clock, ready for the next one
      sh <= {sh[46:0], ~sh[47]};
    end
  end

  assign sid_o = sh[47];

  // sample on rising link clock, whole 36-bit frame latched
  always_ff @(posedge clk_i) begin
    if (sclk_i && !sclk_q) begin
      rx <= {rx[34:0], sod_i};
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      out_o <= '0;
    end else if (latch_i) begin
      out_o <= rx;
    end
  end
endmodule : hpc_glue

`default_nettype wire

/* tb/testbench.sv */
// self-checking bench for the hot-plug controller front end
// assumes hpc_top and hpc_glue compiled before this file
`timescale 1ns/1ns
`default_nettype none

module testbench;
  logic clk_i = 0, nrst_i = 0, pg = 0, rd = 0, wr = 0, req = 0;
  logic [3:0] strap = 4'h0;
  logic [7:0] addr = 8'h00, in1 = 8'hff, in2 = 8'hff;
  logic [35:0] cdata = 36'h0;
  logic [47:0] frame = '1;
  wire logic [31:0] rdata;
  wire logic [47:0] status;
  wire logic [35:0] gout;
  wire logic [4:0] cnt;
  wire logic [1:0] pwr, cclk, cbus, crst, power_indicator_bit, attention_indicator_bit;
  wire logic ack, busy, sval, sclk, ldn, sid, sod, latch, hpen, smode;
  int n_errors = 0, compares = 0, nclk = 0, nlat = 0;
  logic [3:0] s;
  logic [4:0] ec [8] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h05,
                         5'h06, 5'h01};

  hpc_top dut (.clk_i(clk_i), .nrst_i(nrst_i), .power_good_input_i(pg),
    .hotplug_strap_i(strap), .reg_rd_i(rd), .reg_wr_i(wr),
    .reg_addr_i(addr), .reg_rdata_o(rdata), .reg_ack_o(ack),
    .ctrl_req_i(req), .ctrl_data_i(cdata), .ctrl_busy_o(busy),
    .slot_status_o(status), .status_valid_o(sval), .ser_clk_o(sclk),
    .ser_in_load_n_o(ldn), .ser_sid_i(sid), .ser_sod_o(sod),
    .ser_out_latch_o(latch), .par_in_slot1_i(in1),
    .par_in_slot2_i(in2), .par_power_on_o(pwr),
    .par_clock_conn_n_o(cclk), .par_bus_conn_n_o(cbus),
    .par_slot_rst_n_o(crst), .power_indicator_led_n_o(power_indicator_bit),
    .attention_led_n_o(attention_indicator_bit), .hp_enabled_o(hpen),
    .serial_mode_o(smode), .slot_count_o(cnt));

  hpc_glue glue (.clk_i(clk_i), .nrst_i(nrst_i), .sclk_i(sclk),
    .load_n_i(ldn), .sod_i(sod), .latch_i(latch), .frame_i(frame),
    .sid_o(sid), .out_o(gout));

  always #50 clk_i = ~clk_i;

  always @(posedge clk_i) begin
    if (sclk === 1'b1) nclk++;
    if (latch === 1'b1) nlat++;
  end

  task automatic chk(string nm, logic [47:0] e, logic [47:0] g);
    compares++;
    if (g !== e) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic end_of_test;
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : end_of_test

  task automatic start(logic [3:0] st);
    @(negedge clk_i);
    nrst_i = 0;
    pg = 0;
    strap = st;
    repeat (16) @(negedge clk_i);
    nrst_i = 1;
    @(negedge clk_i);
    pg = 1;
    repeat (3) @(negedge clk_i);
    strap = ~st;
  endtask : start

  task automatic rdreg(logic [7:0] a, logic ea, logic [31:0] ed);
    @(negedge clk_i);
    rd = 1;
    addr = a;
    @(negedge clk_i);
    rd = 0;
    chk("ack", {47'h0, ea}, {47'h0, ack});
    chk("rdata", {16'h0, ed}, {16'h0, rdata});
  endtask : rdreg

  task automatic wrreg(logic [7:0] a);
    @(negedge clk_i);
    wr = 1;
    addr = a;
    @(negedge clk_i);
    wr = 0;
    chk("wr ack", 48'h1, {47'h0, ack});
  endtask : wrreg

  task automatic wait_on(int sel);
    int i;
    for (i = 0; i < 800; i++) begin
      @(negedge clk_i);
      if (sel == 0 && sval === 1'b1) return;
      if (sel == 1 && busy === 1'b0) return;
    end
    n_errors++;
    $display("wrong value wait %0d expected 1 seen 0", sel);
    end_of_test();
  endtask : wait_on

  task automatic push(logic [35:0] d);
    @(negedge clk_i);
    req = 1;
    cdata = d;
    @(negedge clk_i);
    req = 0;
    wait_on(1);
    repeat (3) @(negedge clk_i);
  endtask : push

  function automatic logic [47:0] pins();
    return {36'h0, pwr, cclk, cbus, crst, power_indicator_bit, attention_indicator_bit};
  endfunction : pins

  initial begin
    #2000000;
    n_errors++;
    $display("wrong value watchdog expected 0 seen 1");
    end_of_test();
  end

  initial begin
    for (int i = 0; i < 8; i++) begin
      start(i[3:0]);
      chk("count", {43'h0, i[4:0] + 5'h01}, {43'h0, cnt});
    end
    chk("enabled", 48'h0, {47'h0, hpen});
    rdreg(8'h0c, 1'b0, 32'h0);
    nclk = 0;
    push(36'h0);
    chk("idle pins", 48'h3ff, pins());
    chk("link clk", 48'h0, nclk);
    $display("test disabled done");
    for (int i = 0; i < 8; i++) begin
      s = 4'h8 + i[3:0];
      start(s);
      chk("count", {43'h0, ec[i]}, {43'h0, cnt});
      if (i > 0) chk("mode", {47'h0, i > 2 && i < 7}, smode);
      rdreg(8'h0c, 1'b1, {27'h0, ec[i]});
      wrreg(8'h0c);
      rdreg(8'h0c, 1'b1, {27'h0, ec[i]});
      chk("mode kept", {47'h0, i > 2 && i < 7}, smode);
      chk("enabled", {47'h0, i != 0}, {47'h0, hpen});
      rdreg(8'h10, 1'b1, 32'h0);
    end
    $display("test straps done");
    start(4'ha);
    in1 = 8'h5a;
    in2 = 8'h3c;
    nclk = 0;
    wait_on(0);
    wait_on(0);
    chk("par status", {in1, in2, 32'hffffffff}, status);
    push({24'h0, 6'h15, 6'h2a});
    chk("par pins", 48'h666, pins());
    chk("par pins", 48'h666, pins());
    chk("link clk", 48'h0, nclk);
    start(4'h9);
    push({24'h0, 6'h15, 6'h2a});
    chk("one slot", 48'h6ee, pins());
    $display("test parallel done");
    start(4'he);
    frame = 48'h0123456789ab;
    nlat = 0;
    wait_on(0);
    wait_on(0);
    chk("ser status", frame, status);
    chk("no push", 48'h0, nlat);
    push(36'h987654321);
    chk("ser out", 48'h987654321, {12'h0, gout});
    chk("one push", 48'h1, nlat);
    chk("ser pins", 48'h3ff, pins());
    start(4'hb);
    wait_on(0);
    wait_on(0);
    chk("three slots", {frame[47:24], 24'hffffff}, status);
    $display("test serial done");
    end_of_test();
  end
endmodule : testbench

`default_nettype wire
